//--- inc/gtrc_pkg.sv
// Shared constants, register map and carrier types of the reload/capture timer
`default_nettype none

package gtrc_pkg;

  // ==========================================================================
  // Sizes and timing
  // ==========================================================================
  localparam int CNT_W_DEF    = 16;  // Count and reload width
  localparam int TICK_DIV_DEF = 12;  // Clock cycles per timer tick
  localparam int ADDR_W       = 8;   // Register bus address width
  localparam int DATA_W       = 32;  // Register bus data width

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_COUNT  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_RELOAD = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_PINS   = 8'h14;

  // ==========================================================================
  // Field layouts and reset values
  // ==========================================================================
  typedef struct packed {
    logic edge_rise;     // 1: rising trigger edge, 0: falling
    logic ext_en;        // Trigger pin edges reload or capture
    logic updown;        // Direction from trigger pin level
    logic counter_sel;   // 1: count pin edges, 0: divided clock
    logic capture_mode;  // 1: capture, 0: auto-reload
    logic run;           // Counting enabled
  } gtrc_ctrl_s;

  localparam int          CTRL_W   = $bits(gtrc_ctrl_s);
  localparam logic [5:0]  CTRL_RST = 6'h00;

  localparam int         STAT_W     = 2;
  localparam int         STAT_OVF   = 0;  // Overflow: reload, or wrap to zero in capture mode
  localparam int         STAT_EXT   = 1;  // Trigger reload or capture
  localparam logic [1:0] STAT_RST   = 2'h0;
  localparam logic [1:0] MASK_RST   = 2'h0;

  localparam int PIN_COUNT_BIT = 0;
  localparam int PIN_TRIG_BIT  = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Synchronised pin with its edges
  typedef struct packed {
    logic level;
    logic fall;
    logic rise;
  } gtrc_pin_s;

endpackage : gtrc_pkg

`default_nettype wire

//--- hw/gtrc_pin_sync.sv
// Two-stage pin synchroniser with edge detection
`default_nettype none
`timescale 1ns/1ps

module gtrc_pin_sync
  import gtrc_pkg::*;
(
  input  wire logic      clk,    // Peripheral clock
  input  wire logic      rst_n,  // Synchronous reset, active low
  input  wire logic      pin,    // Asynchronous pin
  output gtrc_pin_s      pin_o   // Level and one-cycle edges
);

  logic meta;
  logic stable;
  logic last;
  logic next_meta;
  logic next_stable;
  logic next_last;

  // ==========================================================================
  // Sampling
  // ==========================================================================
  // Edge logic compares the second and third stages; every sampled change
  // gives a one-cycle edge, so only pin pulses shorter than a clock are lost.
  always_comb begin
    next_meta   = pin;
    next_stable = meta;
    next_last   = stable;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta   <= 1'b1;
      stable <= 1'b1;
      last   <= 1'b1;
    end else begin
      meta   <= next_meta;
      stable <= next_stable;
      last   <= next_last;
    end
  end

  assign pin_o = '{level: stable,
                   fall:  last & ~stable,
                   rise:  ~last & stable};

endmodule : gtrc_pin_sync

`default_nettype wire

//--- hw/gtrc_timer.sv
// Sixteen-bit reload/capture timer with AXI4-Lite register access
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`default_nettype none
`timescale 1ns/1ps

module gtrc_timer
  import gtrc_pkg::*;
#(
  parameter int CNT_W    = CNT_W_DEF,    // Counter width
  parameter int TICK_DIV = TICK_DIV_DEF  // Clocks per timer tick
) (
  input  wire logic              clk,                    // Peripheral clock
  input  wire logic              rst_n,                  // Sync reset, low
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,           // Write address
  input  wire logic              s_axi_awvalid,          // Write addr valid
  output logic                   s_axi_awready,          // Write addr ready
  input  wire logic [DATA_W-1:0] s_axi_wdata,            // Write data
  input  wire logic [3:0]        s_axi_wstrb,            // Byte enables
  input  wire logic              s_axi_wvalid,           // Write data valid
  output logic                   s_axi_wready,           // Write data ready
  output logic [1:0]             s_axi_bresp,            // Write response
  output logic                   s_axi_bvalid,           // Response valid
  input  wire logic              s_axi_bready,           // Response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,           // Read address
  input  wire logic              s_axi_arvalid,          // Read addr valid
  output logic                   s_axi_arready,          // Read addr ready
  output logic [DATA_W-1:0]      s_axi_rdata,            // Read data
  output logic [1:0]             s_axi_rresp,            // Read response
  output logic                   s_axi_rvalid,           // Read data valid
  input  wire logic              s_axi_rready,           // Read data ready
  input  wire logic              count_input_pin,        // External count
  input  wire logic              trigger_direction_pin,  // Trigger/direction
  output logic                   irq                     // Interrupt, high
);

  localparam int PW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
  localparam logic [PW-1:0] PRESC_LAST = PW'(TICK_DIV - 1);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (CNT_W < 2 || CNT_W > DATA_W) begin : g_bad_width
    $error("CNT_W must lie between 2 and the bus data width");
  end
  if (TICK_DIV < 2) begin : g_bad_div
    $error("TICK_DIV must be at least 2");
  end

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  gtrc_pin_s cnt_pin;
  gtrc_pin_s trg_pin;

  gtrc_pin_sync u_count_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (count_input_pin),
    .pin_o (cnt_pin)
  );

  gtrc_pin_sync u_trig_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (trigger_direction_pin),
    .pin_o (trg_pin)
  );

  // ==========================================================================
  // Bus state
  // ==========================================================================
  logic              aw_hold;
  logic              w_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [3:0]        w_strb;
  logic              bvalid;
  logic [1:0]        bresp;
  logic              rvalid;
  logic [DATA_W-1:0] rdata;
  logic [1:0]        rresp;
  logic              next_aw_hold;
  logic              next_w_hold;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [DATA_W-1:0] next_w_data;
  logic [3:0]        next_w_strb;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_rvalid;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0]        next_rresp;

  // ==========================================================================
  // Timer state
  // ==========================================================================
  gtrc_ctrl_s        ctrl;
  logic [CNT_W-1:0]  count;
  logic [CNT_W-1:0]  reload;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;
  logic [PW-1:0]     presc;
  gtrc_ctrl_s        next_ctrl;
  logic [CNT_W-1:0]  next_count;
  logic [CNT_W-1:0]  next_reload;
  logic [STAT_W-1:0] next_status;
  logic [STAT_W-1:0] next_mask;
  logic [PW-1:0]     next_presc;

  logic              wr_fire;
  logic              wr_hit;
  logic [DATA_W-1:0] wr_bits;
  logic [DATA_W-1:0] rd_word;
  logic              rd_hit;

  // Byte-enable merge of a write into a register image
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{w_strb[b]}};
    end
    return (old & ~m) | (w_data & m);
  endfunction : merge

  // ==========================================================================
  // AXI4-Lite slave
  // ==========================================================================
  assign s_axi_awready = ~aw_hold & ~bvalid;
  assign s_axi_wready  = ~w_hold & ~bvalid;
  assign s_axi_arready = ~rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;
  assign wr_fire       = aw_hold & w_hold & ~bvalid;

  always_comb begin
    wr_hit = 1'b1;
    case (aw_addr)
      ADDR_CTRL, ADDR_COUNT, ADDR_RELOAD, ADDR_STATUS, ADDR_MASK: ;
      ADDR_PINS: ;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      ADDR_CTRL:   rd_word[CTRL_W-1:0] = ctrl;
      ADDR_COUNT:  rd_word[CNT_W-1:0]  = count;
      ADDR_RELOAD: rd_word[CNT_W-1:0]  = reload;
      ADDR_STATUS: rd_word[STAT_W-1:0] = status;
      ADDR_MASK:   rd_word[STAT_W-1:0] = mask;
      ADDR_PINS: begin
        rd_word[PIN_COUNT_BIT] = cnt_pin.level;
        rd_word[PIN_TRIG_BIT]  = trg_pin.level;
      end
      default:     rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold  = w_hold;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_hit ? RESP_OKAY : RESP_DECERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_word;
      next_rresp  = rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      aw_addr <= '0;
      w_hold  <= 1'b0;
      w_data  <= '0;
      w_strb  <= '0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      aw_hold <= next_aw_hold;
      aw_addr <= next_aw_addr;
      w_hold  <= next_w_hold;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // ==========================================================================
  // Counter core
  // ==========================================================================
  logic              tick;
  logic              trig_edge;
  logic              at_ones;
  logic [STAT_W-1:0] events;

  assign at_ones   = (count == {CNT_W{1'b1}});
  assign trig_edge = ctrl.run & ctrl.ext_en
                   & (ctrl.edge_rise ? trg_pin.rise : trg_pin.fall);
  // Counter mode counts every falling edge, even with each level held for only one clock
  assign tick      = ctrl.run & (ctrl.counter_sel ? cnt_pin.fall
                                                  : presc == PRESC_LAST);

  always_comb begin
    wr_bits     = merge('0);
    next_ctrl   = ctrl;
    next_count  = count;
    next_reload = reload;
    next_mask   = mask;
    next_presc  = '0;
    events      = '0;
    if (ctrl.run && !ctrl.counter_sel) begin
      next_presc = (presc == PRESC_LAST) ? '0 : presc + 1'b1;
    end
    if (ctrl.capture_mode) begin
      if (tick) begin
        next_count       = at_ones ? '0 : count + 1'b1;
        events[STAT_OVF] = at_ones;
      end
    end else if (ctrl.updown) begin
      // No events in this mode, so the interrupt stays quiet
      if (tick && trg_pin.level) begin
        next_count = at_ones ? reload : count + 1'b1;
      end else if (tick) begin
        next_count = (count == reload) ? {CNT_W{1'b1}}
                                       : count - 1'b1;
      end
    end else if (trig_edge) begin
      next_count       = reload;
      events[STAT_EXT] = 1'b1;
    end else if (tick) begin
      next_count       = at_ones ? reload : count + 1'b1;
      events[STAT_OVF] = at_ones;
    end
    // Software writes win over ticks; a capture wins over a reload write
    if (wr_fire && aw_addr == ADDR_CTRL) begin
      next_ctrl = CTRL_W'(merge(DATA_W'(ctrl)));
    end
    if (wr_fire && aw_addr == ADDR_COUNT) begin
      next_count = CNT_W'(merge(DATA_W'(count)));
    end
    if (wr_fire && aw_addr == ADDR_RELOAD) begin
      next_reload = CNT_W'(merge(DATA_W'(reload)));
    end
    if (wr_fire && aw_addr == ADDR_MASK) begin
      next_mask = STAT_W'(merge(DATA_W'(mask)));
    end
    if (ctrl.capture_mode && trig_edge) begin
      next_reload      = count;
      events[STAT_EXT] = 1'b1;
    end
    next_status = status;
    if (wr_fire && aw_addr == ADDR_STATUS) begin
      next_status = status & ~wr_bits[STAT_W-1:0];
    end
    next_status = next_status | events;  // Set wins over clear
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl   <= CTRL_RST;
      count  <= '0;
      reload <= '0;
      status <= STAT_RST;
      mask   <= MASK_RST;
      presc  <= '0;
    end else begin
      ctrl   <= next_ctrl;
      count  <= next_count;
      reload <= next_reload;
      status <= next_status;
      mask   <= next_mask;
      presc  <= next_presc;
    end
  end

  assign irq = |(status & mask);

endmodule : gtrc_timer

`default_nettype wire

//--- verif/gtrc_timer_props.sv
// Bus and interrupt checker of the reload/capture timer
`timescale 1ns/1ps
`default_nettype none

module gtrc_timer_props
  import gtrc_pkg::*;
(
  input wire logic              clk,           // Clock
  input wire logic              rst_n,         // Reset, low
  input wire logic              s_axi_awvalid, // AW valid
  input wire logic              s_axi_awready, // AW ready
  input wire logic              s_axi_wvalid,  // W valid
  input wire logic              s_axi_wready,  // W ready
  input wire logic [1:0]        s_axi_bresp,   // B response
  input wire logic              s_axi_bvalid,  // B valid
  input wire logic              s_axi_bready,  // B ready
  input wire logic              s_axi_arvalid, // AR valid
  input wire logic              s_axi_arready, // AR ready
  input wire logic [DATA_W-1:0] s_axi_rdata,   // Read data
  input wire logic              s_axi_rvalid,  // R valid
  input wire logic              s_axi_rready,  // R ready
  input wire logic              irq            // Interrupt
);
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read not answered");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
  aw_refuse_a: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("aw taken early");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("ar taken early");
  reset_quiet_a: assert property ($rose(rst_n)
    |-> !irq && !s_axi_bvalid && !s_axi_rvalid) else $error("not idle");
  irq_clear_a: assert property ($fell(irq) |-> s_axi_bvalid)
    else $error("irq fell without write");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(irq));
endmodule : gtrc_timer_props

`default_nettype wire

//--- verif/gtrc_pin_model.sv
// Model of the sources driving the count and trigger pins
`timescale 1ns/1ps
`default_nettype none

module gtrc_pin_model (
  input  wire logic clk,                  // Clock
  output var logic  count_input_pin,      // Count source
  output var logic  trigger_direction_pin // Trigger source
);
  // Both lines idle high, as with a pull-up
  initial begin
    count_input_pin = 1'b1;
    trigger_direction_pin = 1'b1;
  end

  // Each count spans 25 clocks, so no edge is lost
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk) count_input_pin <= 1'b0;
      repeat (12) @(posedge clk);
      count_input_pin <= 1'b1;
      repeat (12) @(posedge clk);
    end
  endtask : pulse

  task automatic set_trig(input logic v);
    @(posedge clk) trigger_direction_pin <= v;
    repeat (8) @(posedge clk);
  endtask : set_trig
endmodule : gtrc_pin_model

`default_nettype wire

//--- verif/tb_gtrc_timer.sv
// Self-checking testbench of the reload/capture timer
`timescale 1ns/1ps
`default_nettype none

module tb_gtrc_timer import gtrc_pkg::*;;
  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] s_axi_awaddr;
  logic [ADDR_W-1:0] s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata;
  logic [3:0]        s_axi_wstrb;
  logic              s_axi_awvalid;
  logic              s_axi_wvalid;
  logic              s_axi_bready;
  logic              s_axi_arvalid;
  logic              s_axi_rready;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  logic [DATA_W-1:0] s_axi_rdata, d;
  wire logic         count_input_pin, trigger_direction_pin;
  int                miscompares = 0, comparisons = 0, cycles = 0;

  always #2 clk = ~clk;

  gtrc_timer i_gtrc_timer (
    .clk                   (clk),
    .rst_n                 (rst_n),
    .s_axi_awaddr          (s_axi_awaddr),
    .s_axi_awvalid         (s_axi_awvalid),
    .s_axi_awready         (s_axi_awready),
    .s_axi_wdata           (s_axi_wdata),
    .s_axi_wstrb           (s_axi_wstrb),
    .s_axi_wvalid          (s_axi_wvalid),
    .s_axi_wready          (s_axi_wready),
    .s_axi_bresp           (s_axi_bresp),
    .s_axi_bvalid          (s_axi_bvalid),
    .s_axi_bready          (s_axi_bready),
    .s_axi_araddr          (s_axi_araddr),
    .s_axi_arvalid         (s_axi_arvalid),
    .s_axi_arready         (s_axi_arready),
    .s_axi_rdata           (s_axi_rdata),
    .s_axi_rresp           (s_axi_rresp),
    .s_axi_rvalid          (s_axi_rvalid),
    .s_axi_rready          (s_axi_rready),
    .count_input_pin       (count_input_pin),
    .trigger_direction_pin (trigger_direction_pin),
    .irq                   (irq)
  );
  gtrc_pin_model i_gtrc_pin_model (
    .clk                   (clk),
    .count_input_pin       (count_input_pin),
    .trigger_direction_pin (trigger_direction_pin)
  );

  // ==========================================================================
  // Bus cycles and comparison
  // ==========================================================================
  // Ready is sampled at the falling edge, where it has settled
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta = 1'b0, tw = 1'b0, ea, ew;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge clk);
      ea = s_axi_awvalid && s_axi_awready;
      ew = s_axi_wvalid && s_axi_wready;
      @(posedge clk);
      if (ea) s_axi_awvalid <= 1'b0;
      if (ew) s_axi_wvalid <= 1'b0;
      ta |= ea;
      tw |= ew;
    end while (!(ta && tw));
    do @(negedge clk); while (!s_axi_bvalid);
    @(posedge clk) s_axi_bready <= 1'b1;
    @(negedge clk) r = s_axi_bresp;
    @(posedge clk) s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  // Late ready keeps the answer standing for a while
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge clk); while (!s_axi_arready);
    @(posedge clk) s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (!s_axi_rvalid);
    @(posedge clk) s_axi_rready <= 1'b1;
    @(negedge clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk) s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask : rc

  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset;
    for (int i = 0; i < 5; i++) rc(8'(4 * i), 32'h0000_0000);
    rc(ADDR_PINS, 32'h0000_0003);
    rd(8'h18);
    chk({30'h0, r}, {30'h0, RESP_DECERR});
    wr(8'h18, 32'h0000_ffff);
    chk({30'h0, r}, {30'h0, RESP_DECERR});
    // Only the low byte lane may land
    s_axi_wstrb <= 4'h1;
    wr(ADDR_RELOAD, 32'h0000_5678);
    s_axi_wstrb <= 4'hf;
    rc(ADDR_RELOAD, 32'h0000_0078);
  endtask : t_reset

  // Start and stop jitter by a write latency, hence the window
  task automatic t_timer;
    wr(ADDR_CTRL, 32'h0000_0001);
    repeat (236) @(posedge clk);
    wr(ADDR_CTRL, 32'h0000_0000);
    rd(ADDR_COUNT);
    chk(32'(d >= 19 && d <= 21), 32'h0000_0001);
  endtask : t_timer

  task automatic t_overflow;
    wr(ADDR_MASK, 32'h0000_0003);
    wr(ADDR_RELOAD, 32'h0000_1234);
    wr(ADDR_COUNT, 32'h0000_ffff);
    wr(ADDR_CTRL, 32'h0000_0005);
    i_gtrc_pin_model.pulse(1);
    rc(ADDR_COUNT, 32'h0000_1234);
    rc(ADDR_STATUS, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    i_gtrc_pin_model.set_trig(1'b0);
    i_gtrc_pin_model.set_trig(1'b1);
    rc(ADDR_COUNT, 32'h0000_1234);
    wr(ADDR_STATUS, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(ADDR_MASK, 32'h0000_0000);
    wr(ADDR_COUNT, 32'h0000_ffff);
    i_gtrc_pin_model.pulse(1);
    rc(ADDR_STATUS, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(ADDR_STATUS, 32'h0000_0001);
    wr(ADDR_MASK, 32'h0000_0003);
  endtask : t_overflow

  task automatic t_trigger;
    wr(ADDR_RELOAD, 32'h0000_00a5);
    wr(ADDR_COUNT, 32'h0000_0007);
    wr(ADDR_CTRL, 32'h0000_0015);
    i_gtrc_pin_model.set_trig(1'b0);
    rc(ADDR_COUNT, 32'h0000_00a5);
    rc(ADDR_STATUS, 32'h0000_0002);
    wr(ADDR_CTRL, 32'h0000_0035);
    wr(ADDR_COUNT, 32'h0000_0007);
    i_gtrc_pin_model.set_trig(1'b1);
    rc(ADDR_COUNT, 32'h0000_00a5);
    wr(ADDR_COUNT, 32'h0000_0007);
    i_gtrc_pin_model.set_trig(1'b0);
    rc(ADDR_COUNT, 32'h0000_0007);
    wr(ADDR_STATUS, 32'h0000_0003);
  endtask : t_trigger

  // Trigger pin low counts down, high counts up
  task automatic t_updown;
    wr(ADDR_RELOAD, 32'h0000_0003);
    wr(ADDR_COUNT, 32'h0000_0005);
    wr(ADDR_CTRL, 32'h0000_000d);
    i_gtrc_pin_model.pulse(3);
    rc(ADDR_COUNT, 32'h0000_ffff);
    i_gtrc_pin_model.pulse(1);
    rc(ADDR_COUNT, 32'h0000_fffe);
    i_gtrc_pin_model.set_trig(1'b1);
    i_gtrc_pin_model.pulse(2);
    rc(ADDR_COUNT, 32'h0000_0003);
    rc(ADDR_STATUS, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask : t_updown

  task automatic t_capture;
    wr(ADDR_COUNT, 32'h0000_fffe);
    wr(ADDR_CTRL, 32'h0000_0017);
    i_gtrc_pin_model.pulse(2);
    rc(ADDR_COUNT, 32'h0000_0000);
    rc(ADDR_STATUS, 32'h0000_0001);
    i_gtrc_pin_model.pulse(2);
    i_gtrc_pin_model.set_trig(1'b0);
    rc(ADDR_RELOAD, 32'h0000_0002);
    rc(ADDR_STATUS, 32'h0000_0003);
    chk({31'h0, irq}, 32'h0000_0001);
  endtask : t_capture

  // Reset in mid-run drops a pending interrupt and all registers
  task automatic t_rerun;
    i_gtrc_pin_model.set_trig(1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    t_reset();
  endtask : t_rerun

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    clk           = 1'b0;
    rst_n         <= 1'b0;
    s_axi_awaddr  <= '0;
    s_axi_araddr  <= '0;
    s_axi_wdata   <= '0;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    s_axi_bready  <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_timer();
    t_overflow();
    t_trigger();
    t_updown();
    t_capture();
    t_rerun();
    give_verdict();
  end
endmodule : tb_gtrc_timer

bind gtrc_timer gtrc_timer_props i_gtrc_timer_props (
  .clk           (clk),
  .rst_n         (rst_n),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .irq           (irq)
);

`default_nettype wire
